/* src/arf_top.sv */
// Overview of operation
// - 128 integer registers, 64 bits, all readable
// - Integer 0-31 static, 32-127 stacked
// - Integer entry zero always reads zero
// - Integer entry zero write raises fault
// - Stacked integers usable only inside frame
// - 128 floating-point registers, 82 bits each
// - Float entries zero/one read +0.0/+1.0
// - Writing float entry zero/one faults
// - Float 0-31 static, 32-127 rotating
// - Float file: eight reads, six writes
// - Four loads, two results, two stores
// - 64 one-bit condition registers
// - Condition zero reads one, writes dropped
// - Condition 0-15 static, 16-63 rotating
// - Eight 64-bit branch-target registers
// - Integer reads bypass same-cycle writes
`timescale 1ns/1ns
module arf_top #(
	parameter int INT_RD = arf_pkg::ARF_INT_RD,
	parameter int INT_WR = arf_pkg::ARF_INT_WR,
	parameter int CND_RD = arf_pkg::ARF_CND_RD,
	parameter int CND_WR = arf_pkg::ARF_CND_WR,
	parameter int BR_RD = arf_pkg::ARF_BR_RD
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register frame sizes of the stacked integer partition
	input wire arf_pkg::arf_idx_t frame_locals,
	input wire arf_pkg::arf_idx_t frame_outputs,
	// Integer read ports
	input wire arf_pkg::arf_idx_t [INT_RD-1:0] int_rd_idx,
	output arf_pkg::arf_word_t [INT_RD-1:0] int_rd_data_r,
	output logic [INT_RD-1:0] int_rd_fault_r,
	// Integer write ports
	input wire logic [INT_WR-1:0] int_wr_en,
	input wire arf_pkg::arf_idx_t [INT_WR-1:0] int_wr_idx,
	input wire arf_pkg::arf_word_t [INT_WR-1:0] int_wr_data,
	output logic [INT_WR-1:0] int_wr_fault_r,
	// Floating-point ports
	input wire arf_pkg::arf_idx_t fp_rot_base,
	input wire arf_pkg::arf_idx_t [arf_pkg::ARF_FP_RD-1:0] fp_rd_idx,
	output arf_pkg::arf_fpv_t [arf_pkg::ARF_FP_RD-1:0] fp_rd_data_r,
	input wire logic [arf_pkg::ARF_FP_WR-1:0] fp_wr_en,
	input wire arf_pkg::arf_idx_t [arf_pkg::ARF_FP_WR-1:0] fp_wr_idx,
	input wire arf_pkg::arf_fpv_t [arf_pkg::ARF_FP_WR-1:0] fp_wr_data,
	output logic [arf_pkg::ARF_FP_WR-1:0] fp_wr_fault_r,
	// Condition ports
	input wire arf_pkg::arf_cidx_t cnd_rot_base,
	input wire arf_pkg::arf_cidx_t [CND_RD-1:0] cnd_rd_idx,
	output logic [CND_RD-1:0] cnd_rd_data_r,
	input wire logic [CND_WR-1:0] cnd_wr_en,
	input wire arf_pkg::arf_cidx_t [CND_WR-1:0] cnd_wr_idx,
	input wire logic [CND_WR-1:0] cnd_wr_data,
	// Branch-target ports
	input wire arf_pkg::arf_bidx_t [BR_RD-1:0] br_rd_idx,
	output arf_pkg::arf_word_t [BR_RD-1:0] br_rd_data_r,
	input wire logic br_wr_en,
	input wire arf_pkg::arf_bidx_t br_wr_idx,
	input wire arf_pkg::arf_word_t br_wr_data
);
	import arf_pkg::*;

	// Integer storage; entry 0 is never written
	arf_word_t int_mem [ARF_INT_N];
	// Branch-target storage
	arf_word_t br_mem [ARF_BR_N];
	// Combinational integer read values after bypass
	arf_word_t [INT_RD-1:0] int_rd_nxt;
	// Integer write ports that really commit this cycle
	logic [INT_WR-1:0] int_wr_ok;

	// True when an integer index lies in the static part or inside the frame
	function automatic logic in_frame(arf_idx_t idx);
		logic [7:0] size;
		size = {1'b0, frame_locals} + {1'b0, frame_outputs};
		in_frame = (idx < arf_idx_t'(ARF_INT_STATIC)) ||
			({1'b0, idx} - 8'(ARF_INT_STATIC) < size);
	endfunction

	// Qualify integer writes: no entry zero, no index outside the frame
	always_comb begin
		for (int p = 0; p < INT_WR; p++) begin
			int_wr_ok[p] = int_wr_en[p] && int_wr_idx[p] != ARF_IDX_ZERO
				&& in_frame(int_wr_idx[p]);
		end
	end

	// Commit integer writes, higher port wins on a clash
	always_ff @(posedge mclk) begin
		for (int p = 0; p < INT_WR; p++) begin
			if (int_wr_ok[p]) begin
				int_mem[int_wr_idx[p]] <= int_wr_data[p];
			end
		end
	end

	// Fault flags for refused integer writes
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			int_wr_fault_r <= '0;
		end else begin
			for (int p = 0; p < INT_WR; p++) begin
				int_wr_fault_r[p] <= int_wr_en[p] && !int_wr_ok[p];
			end
		end
	end

	// Read values: zero entry forced, same-cycle writes forwarded
	always_comb begin
		for (int r = 0; r < INT_RD; r++) begin
			int_rd_nxt[r] = int_mem[int_rd_idx[r]];
			for (int p = 0; p < INT_WR; p++) begin
				if (int_wr_ok[p] && int_wr_idx[p] == int_rd_idx[r]) begin
					int_rd_nxt[r] = int_wr_data[p];
				end
			end
			if (int_rd_idx[r] == ARF_IDX_ZERO) begin
				int_rd_nxt[r] = ARF_WORD_RST;
			end
		end
	end

	// Integer read data and out-of-frame read flags
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			int_rd_data_r <= '{default: ARF_WORD_RST};
			int_rd_fault_r <= '0;
		end else begin
			for (int r = 0; r < INT_RD; r++) begin
				int_rd_data_r[r] <= int_rd_nxt[r];
				int_rd_fault_r[r] <= !in_frame(int_rd_idx[r]);
			end
		end
	end

	// Branch-target writes
	always_ff @(posedge mclk) begin
		if (br_wr_en) begin
			br_mem[br_wr_idx] <= br_wr_data;
		end
	end

	// Branch-target reads
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			br_rd_data_r <= '{default: ARF_WORD_RST};
		end else begin
			for (int r = 0; r < BR_RD; r++) begin
				br_rd_data_r[r] <= br_mem[br_rd_idx[r]];
			end
		end
	end

	// Floating-point file
	arf_fp_file #(
		.RD(ARF_FP_RD),
		.WR(ARF_FP_WR)
	) u_fp (
		.mclk(mclk),
		.rst_b(rst_b),
		.rot_base(fp_rot_base),
		.rd_idx(fp_rd_idx),
		.rd_data_r(fp_rd_data_r),
		.wr_en(fp_wr_en),
		.wr_idx(fp_wr_idx),
		.wr_data(fp_wr_data),
		.wr_fault_r(fp_wr_fault_r)
	);

	// Condition file
	arf_cond_file #(
		.RD(CND_RD),
		.WR(CND_WR)
	) u_cnd (
		.mclk(mclk),
		.rst_b(rst_b),
		.rot_base(cnd_rot_base),
		.rd_idx(cnd_rd_idx),
		.rd_data_r(cnd_rd_data_r),
		.wr_en(cnd_wr_en),
		.wr_idx(cnd_wr_idx),
		.wr_data(cnd_wr_data)
	);

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	property p_int_zero_read;
		int_rd_idx[0] == ARF_IDX_ZERO |=> int_rd_data_r[0] == ARF_WORD_RST;
	endproperty
	a_int_zero_read: assert property (p_int_zero_read) else $error("int 0 not zero");
	property p_int_zero_fault;
		int_wr_en[0] && int_wr_idx[0] == ARF_IDX_ZERO |=> int_wr_fault_r[0];
	endproperty
	a_int_zero_fault: assert property (p_int_zero_fault) else $error("no fault on int 0");
	property p_int_bypass;
		int_wr_en == INT_WR'(1) && int_wr_idx[0] != ARF_IDX_ZERO && in_frame(int_wr_idx[0])
			&& int_rd_idx[0] == int_wr_idx[0] |=> int_rd_data_r[0] == $past(int_wr_data[0]);
	endproperty
	a_int_bypass: assert property (p_int_bypass) else $error("int bypass missed");
	property p_int_frame;
		int_wr_en[0] && !in_frame(int_wr_idx[0]) |=> int_wr_fault_r[0];
	endproperty
	a_int_frame: assert property (p_int_frame) else $error("no fault outside frame");
	property p_int_rd_frame;
		!in_frame(int_rd_idx[0]) |=> int_rd_fault_r[0];
	endproperty
	a_int_rd_frame: assert property (p_int_rd_frame) else $error("no read flag");
	property p_int_ok_no_fault;
		int_wr_en[0] && int_wr_idx[0] != ARF_IDX_ZERO && in_frame(int_wr_idx[0])
			|=> !int_wr_fault_r[0];
	endproperty
	a_int_ok_no_fault: assert property (p_int_ok_no_fault) else $error("spurious int fault");
	property p_br_rw;
		br_wr_en ##1 !br_wr_en && br_rd_idx[BR_RD-1] == $past(br_wr_idx)
			|=> br_rd_data_r[BR_RD-1] == $past(br_wr_data, 2);
	endproperty
	a_br_rw: assert property (p_br_rw) else $error("branch target lost");

	c_int_bypass: cover property (int_wr_en[0] && int_rd_idx[0] == int_wr_idx[0]);
	c_fp_fault: cover property (fp_wr_fault_r[0]);
	c_int_fault: cover property (int_wr_fault_r[0] ##1 int_rd_fault_r[0]);
endmodule

/* common/arf_pkg.sv */
package arf_pkg;
	// Integer file shape
	localparam int ARF_INT_N = 128;
	localparam int ARF_INT_W = 64;
	localparam int ARF_INT_STATIC = 32;
	// Floating-point file shape and port counts
	localparam int ARF_FP_N = 128;
	localparam int ARF_FP_W = 82;
	localparam int ARF_FP_STATIC = 32;
	localparam int ARF_FP_RD = 8;
	localparam int ARF_FP_WR = 6;
	// Condition file shape
	localparam int ARF_CND_N = 64;
	localparam int ARF_CND_STATIC = 16;
	// Branch-target file shape
	localparam int ARF_BR_N = 8;
	localparam int ARF_BR_W = 64;
	// Default port counts of the integer, condition and branch files
	localparam int ARF_INT_RD = 4;
	localparam int ARF_INT_WR = 2;
	localparam int ARF_CND_RD = 4;
	localparam int ARF_CND_WR = 2;
	localparam int ARF_BR_RD = 2;
	// Index types
	typedef logic [6:0] arf_idx_t;
	typedef logic [5:0] arf_cidx_t;
	typedef logic [2:0] arf_bidx_t;
	typedef logic [63:0] arf_word_t;
	typedef logic [81:0] arf_fpv_t;
	// Hardwired entries and their values
	localparam arf_idx_t ARF_IDX_ZERO = 7'h00;
	localparam arf_idx_t ARF_FP_IDX_ONE = 7'h01;
	localparam arf_fpv_t ARF_FP_POS_ZERO = 82'h0;
	localparam arf_fpv_t ARF_FP_POS_ONE = {1'h0, 17'h0FFFF, 64'h8000000000000000};
	localparam logic ARF_CND_TRUE = 1'h1;
	// Reset values of read data and fault flags
	localparam arf_word_t ARF_WORD_RST = 64'h0;
	localparam arf_fpv_t ARF_FPV_RST = 82'h0;
	localparam logic ARF_BIT_RST = 1'h0;

	// Maps a logical index onto a physical one, rotating the upper partition
	function automatic arf_idx_t arf_rot_map(arf_idx_t idx, arf_idx_t base,
		arf_idx_t n_static, arf_idx_t n_total);
		logic [7:0] rot;
		logic [7:0] b;
		logic [7:0] off;
		rot = {1'b0, n_total - n_static};
		b = {1'b0, base};
		if (b >= rot) begin
			b = b - rot;
		end
		off = {1'b0, idx - n_static} + b;
		if (off >= rot) begin
			off = off - rot;
		end
		if (idx < n_static) begin
			arf_rot_map = idx;
		end else begin
			arf_rot_map = n_static + off[6:0];
		end
	endfunction
endpackage

/* src/arf_fp_file.sv */
`timescale 1ns/1ns
module arf_fp_file #(
	parameter int RD = arf_pkg::ARF_FP_RD,
	parameter int WR = arf_pkg::ARF_FP_WR
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Rotation base of the upper partition
	input wire arf_pkg::arf_idx_t rot_base,
	// Read ports
	input wire arf_pkg::arf_idx_t [RD-1:0] rd_idx,
	output arf_pkg::arf_fpv_t [RD-1:0] rd_data_r,
	// Write ports: loads first, then multiply-accumulate results
	input wire logic [WR-1:0] wr_en,
	input wire arf_pkg::arf_idx_t [WR-1:0] wr_idx,
	input wire arf_pkg::arf_fpv_t [WR-1:0] wr_data,
	output logic [WR-1:0] wr_fault_r
);
	import arf_pkg::*;

	// Storage; entries 0 and 1 are never written
	arf_fpv_t mem [ARF_FP_N];
	localparam arf_idx_t STAT = arf_idx_t'(ARF_FP_STATIC);
	localparam arf_idx_t TOT = arf_idx_t'(ARF_FP_N);

	// Commit writes, higher port wins on a clash
	always_ff @(posedge mclk) begin
		for (int p = 0; p < WR; p++) begin
			if (wr_en[p] && wr_idx[p] > ARF_FP_IDX_ONE) begin
				mem[arf_rot_map(wr_idx[p], rot_base, STAT, TOT)] <= wr_data[p];
			end
		end
	end

	// Fault on a write to a constant entry
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wr_fault_r <= '0;
		end else begin
			for (int p = 0; p < WR; p++) begin
				wr_fault_r[p] <= wr_en[p] && wr_idx[p] <= ARF_FP_IDX_ONE;
			end
		end
	end

	// Registered reads with constant entries forced
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_r <= '{default: ARF_FPV_RST};
		end else begin
			for (int r = 0; r < RD; r++) begin
				if (rd_idx[r] == ARF_IDX_ZERO) begin
					rd_data_r[r] <= ARF_FP_POS_ZERO;
				end else if (rd_idx[r] == ARF_FP_IDX_ONE) begin
					rd_data_r[r] <= ARF_FP_POS_ONE;
				end else begin
					rd_data_r[r] <= mem[arf_rot_map(rd_idx[r], rot_base, STAT, TOT)];
				end
			end
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	property p_fp_zero;
		rd_idx[0] == ARF_IDX_ZERO |=> rd_data_r[0] == ARF_FP_POS_ZERO;
	endproperty
	a_fp_zero: assert property (p_fp_zero) else $error("fp entry 0 not zero");
	property p_fp_one;
		rd_idx[1] == ARF_FP_IDX_ONE |=> rd_data_r[1] == ARF_FP_POS_ONE;
	endproperty
	a_fp_one: assert property (p_fp_one) else $error("fp entry 1 not one");
	property p_fp_fault;
		wr_en[0] && wr_idx[0] <= ARF_FP_IDX_ONE |=> wr_fault_r[0];
	endproperty
	a_fp_fault: assert property (p_fp_fault) else $error("fp constant write no fault");
	property p_fp_store;
		wr_en[WR-1] && wr_idx[WR-1] > ARF_FP_IDX_ONE ##1
			rd_idx[WR-1] == $past(wr_idx[WR-1]) && $stable(rot_base)
			|=> rd_data_r[WR-1] == $past(wr_data[WR-1], 2);
	endproperty
	a_fp_store: assert property (p_fp_store) else $error("fp write not read back");
endmodule

/* src/arf_cond_file.sv */
`timescale 1ns/1ns
module arf_cond_file #(
	parameter int RD = arf_pkg::ARF_CND_RD,
	parameter int WR = arf_pkg::ARF_CND_WR
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Rotation base of the upper partition
	input wire arf_pkg::arf_cidx_t rot_base,
	// Read ports
	input wire arf_pkg::arf_cidx_t [RD-1:0] rd_idx,
	output logic [RD-1:0] rd_data_r,
	// Write ports from compares
	input wire logic [WR-1:0] wr_en,
	input wire arf_pkg::arf_cidx_t [WR-1:0] wr_idx,
	input wire logic [WR-1:0] wr_data
);
	import arf_pkg::*;

	// Condition bits; bit 0 stays clear and reads as true
	logic [ARF_CND_N-1:0] bits_r;
	localparam arf_idx_t STAT = arf_idx_t'(ARF_CND_STATIC);
	localparam arf_idx_t TOT = arf_idx_t'(ARF_CND_N);

	// Physical position of a logical condition index
	function automatic arf_cidx_t phys(arf_cidx_t i);
		phys = arf_cidx_t'(arf_rot_map({1'b0, i}, {1'b0, rot_base}, STAT, TOT));
	endfunction

	// Commit compare results; writes to entry 0 vanish
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bits_r <= '0;
		end else begin
			for (int p = 0; p < WR; p++) begin
				if (wr_en[p] && wr_idx[p] != '0) begin
					bits_r[phys(wr_idx[p])] <= wr_data[p];
				end
			end
		end
	end

	// Registered reads
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_r <= '0;
		end else begin
			for (int r = 0; r < RD; r++) begin
				rd_data_r[r] <= (rd_idx[r] == '0) ? ARF_CND_TRUE : bits_r[phys(rd_idx[r])];
			end
		end
	end

	// Physical slots of the last write port and last read port, so the
	// read-back check holds even when the base moves between the two
	arf_cidx_t chk_wr_slot;
	arf_cidx_t chk_rd_slot;
	always_comb begin
		chk_wr_slot = phys(wr_idx[WR-1]);
		chk_rd_slot = phys(rd_idx[RD-1]);
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	property p_cnd_true;
		rd_idx[0] == '0 |=> rd_data_r[0] == ARF_CND_TRUE;
	endproperty
	a_cnd_true: assert property (p_cnd_true) else $error("cond entry 0 not true");
	property p_cnd_wr;
		wr_en[WR-1] && wr_idx[WR-1] != '0 ##1 wr_en == '0 && chk_rd_slot == $past(chk_wr_slot)
			|=> rd_data_r[RD-1] == $past(wr_data[WR-1], 2);
	endproperty
	a_cnd_wr: assert property (p_cnd_wr) else $error("cond write not read back");
endmodule

/* bench/arf_units.sv */
`timescale 1ns/1ns
module arf_units (
	// Clock
	input wire logic mclk,
	// Commit requests from the bench
	input wire logic [1:0] go,
	input wire arf_pkg::arf_idx_t [1:0] go_idx,
	input wire arf_pkg::arf_word_t [1:0] go_data,
	// Integer write ports of the file
	output logic [1:0] int_wr_en,
	output arf_pkg::arf_idx_t [1:0] int_wr_idx,
	output arf_pkg::arf_word_t [1:0] int_wr_data
);
	import arf_pkg::*;
	// Idle lanes show a pattern that moves every cycle
	logic [63:0] junk_r = 64'h0;
	// Pattern generator
	always @(posedge mclk) begin
		junk_r <= {junk_r[62:0], ~junk_r[63]};
	end
	// Strobe only in the commit cycle; idle lanes carry junk
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			int_wr_en[p] = go[p];
			int_wr_idx[p] = go[p] ? go_idx[p] : junk_r[6:0];
			int_wr_data[p] = go[p] ? go_data[p] : junk_r;
		end
	end
endmodule

/* bench/arf_top_bench.sv */
`timescale 1ns/1ns
module arf_top_bench;
	import arf_pkg::*;
	// Clock and reset
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	// Design ports
	arf_idx_t frame_locals, frame_outputs, fp_rot_base;
	arf_cidx_t cnd_rot_base;
	arf_idx_t [3:0] int_rd_idx;
	arf_word_t [3:0] int_rd_data_r;
	logic [3:0] int_rd_fault_r, cnd_rd_data_r;
	logic [1:0] go, int_wr_en, int_wr_fault_r, cnd_wr_en, cnd_wr_data;
	arf_idx_t [1:0] go_idx, int_wr_idx;
	arf_word_t [1:0] go_data, int_wr_data, br_rd_data_r;
	arf_idx_t [7:0] fp_rd_idx;
	arf_fpv_t [7:0] fp_rd_data_r;
	logic [5:0] fp_wr_en, fp_wr_fault_r;
	arf_idx_t [5:0] fp_wr_idx;
	arf_fpv_t [5:0] fp_wr_data;
	arf_cidx_t [3:0] cnd_rd_idx;
	arf_cidx_t [1:0] cnd_wr_idx;
	arf_bidx_t [1:0] br_rd_idx;
	logic br_wr_en;
	arf_bidx_t br_wr_idx;
	arf_word_t br_wr_data;
	// Reference contents
	arf_fpv_t fm [128];
	logic cm [64];
	arf_word_t bm [8];
	arf_word_t im [128];
	// Index tables: frame edges, static edges
	int kl [8] = '{1, 31, 32, 37, 38, 127, 0, 5};
	int fpi [6] = '{0, 1, 2, 31, 32, 127};
	logic [31:0] seed = 32'hEB6338F2;
	int mismatches = 0;
	int tests_run = 0;
	// Clock generator
	always #10 mclk = ~mclk;
	// Far-side units drive the integer writes
	arf_units units (.mclk(mclk), .go(go), .go_idx(go_idx), .go_data(go_data),
		.int_wr_en(int_wr_en), .int_wr_idx(int_wr_idx), .int_wr_data(int_wr_data));
	// Design under test
	arf_top dut (.mclk(mclk), .rst_b(rst_b), .frame_locals(frame_locals),
		.frame_outputs(frame_outputs), .int_rd_idx(int_rd_idx),
		.int_rd_data_r(int_rd_data_r), .int_rd_fault_r(int_rd_fault_r),
		.int_wr_en(int_wr_en), .int_wr_idx(int_wr_idx), .int_wr_data(int_wr_data),
		.int_wr_fault_r(int_wr_fault_r), .fp_rot_base(fp_rot_base), .fp_rd_idx(fp_rd_idx),
		.fp_rd_data_r(fp_rd_data_r), .fp_wr_en(fp_wr_en), .fp_wr_idx(fp_wr_idx),
		.fp_wr_data(fp_wr_data), .fp_wr_fault_r(fp_wr_fault_r),
		.cnd_rot_base(cnd_rot_base), .cnd_rd_idx(cnd_rd_idx), .cnd_rd_data_r(cnd_rd_data_r),
		.cnd_wr_en(cnd_wr_en), .cnd_wr_idx(cnd_wr_idx), .cnd_wr_data(cnd_wr_data),
		.br_rd_idx(br_rd_idx), .br_rd_data_r(br_rd_data_r), .br_wr_en(br_wr_en),
		.br_wr_idx(br_wr_idx), .br_wr_data(br_wr_data));
	// Xorshift stimulus source
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Logical index to physical slot
	function automatic int phy(int idx, int base, int st, int rot);
		return idx < st ? idx : st + (idx - st + base) % rot;
	endfunction
	// Physical slot to logical index under a base
	function automatic int lgc(int ph, int base, int st, int rot);
		return ph < st ? ph : st + (ph - st - base + rot) % rot;
	endfunction
	// One edge, then the fixed drive delay
	task automatic tick();
		@(posedge mclk);
		#2;
	endtask
	// Compare and count
	task automatic check(input logic [81:0] seen, input logic [81:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic conclude();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge mclk);
		mismatches++;
		conclude();
	end
	// Main sequence
	initial begin
		int k, ok, b, bit1;
		int ph [6];
		arf_word_t d;
		{frame_locals, frame_outputs, fp_rot_base, cnd_rot_base} = '0;
		{int_rd_idx, go, go_idx, go_data, fp_rd_idx, fp_wr_en, fp_wr_idx} = '0;
		{fp_wr_data, cnd_rd_idx, cnd_wr_en, cnd_wr_idx, cnd_wr_data} = '0;
		{br_rd_idx, br_wr_en, br_wr_idx, br_wr_data} = '0;
		foreach (cm[i]) cm[i] = 1'b0;
		repeat (16) @(posedge mclk);
		#2;
		rst_b = 1'b1;
		// Integer file: frame of six, bypass, zero entry, port priority
		frame_locals = 7'h04;
		frame_outputs = 7'h02;
		foreach (kl[i]) begin
			k = kl[i];
			d = {xs(), xs()};
			ok = (k != 0) && (k < 32 || k - 32 < 6);
			go = (i == 7) ? 2'b11 : 2'b01;
			go_idx = {arf_idx_t'(k), arf_idx_t'(k)};
			go_data = {~d, d};
			int_rd_idx = {4{arf_idx_t'(k)}};
			tick();
			go = 2'b00;
			check(int_wr_fault_r[0], !ok);
			check(int_rd_fault_r[0], k >= 32 && !ok);
			if (k == 0) begin
				check(int_rd_data_r[2], 64'h0);
			end else if (ok) begin
				im[k] = (i == 7) ? ~d : d;
				check(int_rd_data_r[1], im[k]);
			end
		end
		// Read the stored integers back with no write in flight
		foreach (kl[i]) begin
			k = kl[i];
			if (k != 0 && (k < 32 || k - 32 < 6)) begin
				int_rd_idx = {4{arf_idx_t'(k)}};
				tick();
				for (int r = 0; r < 4; r++) check(int_rd_data_r[r], im[k]);
			end
		end
		// Floating-point file: six writes at once, eight reads, two bases
		b = xs() % 96;
		fp_rot_base = arf_idx_t'(b);
		for (int p = 0; p < 6; p++) begin
			fp_wr_idx[p] = arf_idx_t'(fpi[p]);
			fp_wr_data[p] = arf_fpv_t'({xs(), xs(), xs()});
			ph[p] = phy(fpi[p], b, 32, 96);
			fm[ph[p]] = fp_wr_data[p];
		end
		fp_wr_en = 6'h3F;
		tick();
		fp_wr_en = 6'h00;
		check(fp_wr_fault_r, 6'h03);
		for (int r = 0; r < 2; r++) begin
			fp_rot_base = arf_idx_t'(b);
			for (int p = 0; p < 6; p++) fp_rd_idx[p] = arf_idx_t'(lgc(ph[p], b, 32, 96));
			fp_rd_idx[6] = 7'h00;
			fp_rd_idx[7] = 7'h01;
			tick();
			for (int p = 2; p < 6; p++) check(fp_rd_data_r[p], fm[ph[p]]);
			check(fp_rd_data_r[0], ARF_FP_POS_ZERO);
			check(fp_rd_data_r[7], ARF_FP_POS_ONE);
			check(fp_rd_data_r[1], ARF_FP_POS_ONE);
			check(fp_rd_data_r[6], ARF_FP_POS_ZERO);
			b = xs() % 96;
		end
		// Condition file: dropped zero write, rotating entry
		repeat (4) begin
			b = xs() % 48;
			k = 16 + xs() % 48;
			bit1 = xs() & 1;
			cnd_rot_base = arf_cidx_t'(b);
			cnd_wr_idx = {arf_cidx_t'(k), 6'h00};
			cnd_wr_data = {bit1[0], 1'b0};
			cnd_wr_en = 2'b11;
			cm[phy(k, b, 16, 48)] = bit1[0];
			tick();
			cnd_wr_en = 2'b00;
			cnd_rot_base = arf_cidx_t'(xs() % 48);
			cnd_rd_idx[0] = 6'h00;
			cnd_rd_idx[1] = arf_cidx_t'(lgc(phy(k, b, 16, 48), cnd_rot_base, 16, 48));
			cnd_rd_idx[2] = 6'h00;
			cnd_rd_idx[3] = cnd_rd_idx[1];
			tick();
			check(cnd_rd_data_r[0], 1'b1);
			check(cnd_rd_data_r[1], bit1[0]);
			check(cnd_rd_data_r[2], 1'b1);
			check(cnd_rd_data_r[3], bit1[0]);
		end
		// Branch-target file: fill all eight, read crosswise
		br_wr_en = 1'b1;
		for (int i = 0; i < 8; i++) begin
			bm[i] = {xs(), xs()};
			br_wr_idx = arf_bidx_t'(i);
			br_wr_data = bm[i];
			tick();
		end
		br_wr_en = 1'b0;
		for (int i = 0; i < 8; i++) begin
			br_rd_idx = {arf_bidx_t'(7 - i), arf_bidx_t'(i)};
			tick();
			check(br_rd_data_r[0], bm[i]);
			check(br_rd_data_r[1], bm[7 - i]);
		end
		conclude();
	end
endmodule
